// *** rtl/atde_pkg.sv ***
// Purpose: Shared constants for the async transmit descriptor and expiry engine
// Assumes: 32-bit APB register bus, 32-bit word host memory port
// Notes:   Descriptor word layout and register map live here only
package atde_pkg;
    // APB register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CMDPTR = 8'h08;
    // Control register bit positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_RESP_BIT = 1;
    localparam int CTRL_WAKE_BIT = 2;
    // Channel control word bit positions (low 16 bits)
    localparam int CCW_RUN_BIT = 15;
    localparam int CCW_DEAD_BIT = 11;
    localparam int CCW_ACTIVE_BIT = 10;
    // Reset values
    localparam logic [31:0] CMDPTR_RESET = 32'h0000_0000;
    localparam logic [4:0] EVT_RESET = 5'h00;
    // Event code written on expiry
    localparam logic [4:0] EVT_TIMEOUT = 5'h0a;
    // Descriptor word 0 fields
    localparam int CMD_MSB = 31;
    localparam int CMD_LSB = 28;
    localparam int STATUS_WR_BIT = 27;
    localparam int KEY_MSB = 26;
    localparam int KEY_LSB = 24;
    localparam logic [3:0] CMD_LAST = 4'h1;
    localparam logic [2:0] KEY_IMMEDIATE = 3'h2;
    // Word indices inside one 16-byte unit
    localparam int WORD_BRANCH = 2;
    localparam int WORD_STATUS = 3;
    localparam int WORDS_PER_UNIT = 4;
    localparam logic [31:0] UNIT_BYTES = 32'h0000_0010;
    // Block count limits
    localparam logic [3:0] Z_END = 4'h0;
    localparam int Z_MAX = 8;
    // Cycle number modulus of the time tag
    localparam int CYCLE_MOD = 8000;
    // Engine states
    typedef enum logic [3:0] {
        ST_IDLE, ST_FETCH, ST_SCAN, ST_CHECK, ST_LOAD, ST_WAITACK,
        ST_WRBACK, ST_NEXT, ST_ENDWAIT, ST_RDBR, ST_DEAD
    } atde_state_t;
endpackage

// *** rtl/atde_expiry_check.sv ***
// Purpose: Decide whether a response time tag is still sendable
// Assumes: Both cycle numbers already lie in 0..7999
// Notes:   Pure combinational; the caller samples the verdict
`timescale 1ns/1ps
module atde_expiry_check
    import atde_pkg::*;
(
    // Time values: {low_second_bits[2:0], bus_cycle_number[12:0]}
    input wire logic [15:0] packetTimeTag,
    input wire logic [15:0] busCycleTimer,
    // Verdict
    output logic sendOk,
    output logic [2:0] secDiff
);
    // Signed cycle difference, sign bit prepended to both
    logic [13:0] cycDiff;

    // Seconds modulo eight, then cycles within the same second
    always_comb
    begin
        secDiff = packetTimeTag[15:13] - busCycleTimer[15:13];
        // No wrap fix needed: both operands are below the modulus
        cycDiff = {1'b0, packetTimeTag[12:0]} - {1'b0, busCycleTimer[12:0]};
        if (secDiff[2])
        begin
            sendOk = 1'b0;
        end
        else if (secDiff[1:0] != 2'b00)
        begin
            sendOk = 1'b1;
        end
        else
        begin
            sendOk = ~cycDiff[13];
        end
    end
endmodule

// *** rtl/atde_top.sv ***
// Purpose: Descriptor block fetch, expiry check and status write-back
// Assumes: Memory port answers each request with one memAck pulse
// Notes:   APB slave has zero wait states; unmapped offsets give pslverr
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Block count zero ends program, no fetch
// - Counts 2-8 fetch that many contiguous units
// - One block fully describes one packet
// - Branch taken only from final descriptor
// - Ended program resumes when software appends
// - Status field gets low control word bits
// - Tag is three second bits, 13 cycle bits
// - Request tag sampled from timer on ack
// - Tag and status in one write
// - Responses checked before every load attempt
// - Negative seconds difference rejects response
// - Positive nonzero seconds difference sends response
// - Same second: signed cycle compare decides
// - Rejected response records timeout event
// - Cycle number counts modulo 8000
// - Passed packet never rechecked while loading
// - Write-back only when status bit set
module atde_top
    import atde_pkg::*;
#(
    parameter int MAX_UNITS = Z_MAX
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host memory port
    output logic memReq,
    output logic memWe,
    output logic [31:0] memAddr,
    output logic [31:0] memWdata,
    input wire logic memAck,
    input wire logic [31:0] memRdata,
    // Bus cycle timer {low_second_bits, bus_cycle_number}
    input wire logic [15:0] busCycleTimer,
    // Transmit FIFO load and link acknowledge
    output logic pktValid,
    input wire logic pktReady,
    input wire logic ackValid,
    input wire logic ackRetry,
    input wire logic [4:0] ackCode
);
    localparam int MAX_WORDS = MAX_UNITS * WORDS_PER_UNIT;

    // Buffer index width is fixed at five bits
    if (MAX_UNITS < 2 || MAX_UNITS > Z_MAX)
    begin : g_bad_units
        $error("MAX_UNITS must be 2 to 8");
    end

    ////////////////////////////////////////////////////////////////////
    // Declarations
    atde_state_t state_q; // Engine state
    logic [31:0] descBuf_q [MAX_WORDS]; // Prefetched block
    logic [31:0] cmdPtr_q; // Start pointer with count
    logic [31:0] blkAddr_q; // Current block base
    logic [3:0] zCnt_q; // Units in current block
    logic [4:0] wordIdx_q; // Fetch word index
    logic [3:0] unitIdx_q; // Scan unit index
    logic [3:0] lastUnit_q; // Final descriptor unit
    logic [31:0] brAddr_q; // Address of end descriptor's branch word
    logic runCfg_q; // Context enabled
    logic respCfg_q; // Context carries responses
    logic wakePulse; // Software append notice
    logic dead_q; // Malformed block seen
    logic [4:0] evt_q; // Last event code
    logic [15:0] tagOut_q; // Tag written back
    logic [15:0] ccwLow; // Low channel control word
    logic [31:0] unitW0; // Word 0 of scanned unit
    logic [31:0] lastW0; // Word 0 of final descriptor
    logic [31:0] lastBr; // Branch word of final descriptor
    logic [31:0] lastAddr; // Address of final descriptor
    logic [15:0] firstTag; // Expiry tag of first descriptor
    logic sendOk; // Expiry verdict
    logic [2:0] secDiff; // Seconds difference
    logic apbWr; // APB write access phase
    logic regHit; // Mapped offset

    ////////////////////////////////////////////////////////////////////
    // APB slave
    assign pready = 1'b1;
    assign apbWr = psel & penable & pwrite;
    assign regHit = (paddr == REG_CTRL) || (paddr == REG_STATUS) || (paddr == REG_CMDPTR);
    assign pslverr = psel & penable & ~regHit;
    // Wake is write-one, never stored
    assign wakePulse = apbWr && paddr == REG_CTRL && pwdata[CTRL_WAKE_BIT];

    // Read mux, only status shows engine state
    always_comb
    begin
        case (paddr)
            REG_CTRL: prdata = {30'h0, respCfg_q, runCfg_q};
            REG_STATUS: prdata = {12'h0, state_q, ccwLow};
            REG_CMDPTR: prdata = cmdPtr_q;
            default: prdata = 32'h0000_0000;
        endcase
    end

    // Control bits
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            runCfg_q <= 1'b0;
            respCfg_q <= 1'b0;
        end
        else if (apbWr && paddr == REG_CTRL)
        begin
            runCfg_q <= pwdata[CTRL_RUN_BIT];
            respCfg_q <= pwdata[CTRL_RESP_BIT];
        end
    end

    // Command pointer, written only by software
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            cmdPtr_q <= CMDPTR_RESET;
        else if (apbWr && paddr == REG_CMDPTR)
            cmdPtr_q <= pwdata;
    end

    ////////////////////////////////////////////////////////////////////
    // Descriptor decode
    always_comb
    begin
        ccwLow = 16'h0000;
        ccwLow[CCW_RUN_BIT] = runCfg_q;
        ccwLow[CCW_DEAD_BIT] = dead_q;
        ccwLow[CCW_ACTIVE_BIT] = (state_q != ST_IDLE) && (state_q != ST_ENDWAIT) && (state_q != ST_DEAD);
        ccwLow[4:0] = evt_q;
    end
    assign unitW0 = descBuf_q[5'(unitIdx_q) << 2];
    assign lastW0 = descBuf_q[5'(lastUnit_q) << 2];
    // Continuing descriptors' branch words are never read
    assign lastBr = descBuf_q[(5'(lastUnit_q) << 2) + 5'(WORD_BRANCH)];
    assign lastAddr = blkAddr_q + (32'(lastUnit_q) << 4);
    assign firstTag = descBuf_q[WORD_STATUS][15:0];

    atde_expiry_check u_expiry
    (
        .packetTimeTag(firstTag),
        .busCycleTimer(busCycleTimer),
        .sendOk(sendOk),
        .secDiff(secDiff)
    );

    ////////////////////////////////////////////////////////////////////
    // Memory port, held until acknowledged
    always_comb
    begin
        memReq = 1'b0;
        memWe = 1'b0;
        memAddr = 32'h0000_0000;
        memWdata = 32'h0000_0000;
        case (state_q)
            ST_FETCH:
            begin
                memReq = 1'b1;
                memAddr = blkAddr_q + {25'h0, wordIdx_q, 2'b00};
            end
            ST_WRBACK:
            begin
                // Status and tag share one word write
                memReq = 1'b1;
                memWe = 1'b1;
                memAddr = lastAddr + 32'(WORD_STATUS * 4);
                memWdata = {ccwLow, tagOut_q};
            end
            ST_RDBR:
            begin
                memReq = 1'b1;
                memAddr = brAddr_q;
            end
            default:
            begin
                memReq = 1'b0;
            end
        endcase
    end
    assign pktValid = (state_q == ST_LOAD);

    ////////////////////////////////////////////////////////////////////
    // Block prefetch into flip-flop buffer
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < MAX_WORDS; i++)
                descBuf_q[i] <= 32'h0000_0000;
        end
        else if (state_q == ST_FETCH && memAck)
        begin
            descBuf_q[wordIdx_q] <= memRdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Engine sequencing
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q <= ST_IDLE;
            blkAddr_q <= 32'h0000_0000;
            zCnt_q <= Z_END;
            wordIdx_q <= 5'h00;
            unitIdx_q <= 4'h0;
            lastUnit_q <= 4'h0;
            brAddr_q <= 32'h0000_0000;
            dead_q <= 1'b0;
            evt_q <= EVT_RESET;
            tagOut_q <= 16'h0000;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    // Start from the pointer; zero count means nothing to do
                    if (runCfg_q && cmdPtr_q[3:0] != Z_END)
                    begin
                        blkAddr_q <= {cmdPtr_q[31:4], 4'h0};
                        zCnt_q <= cmdPtr_q[3:0];
                        wordIdx_q <= 5'h00;
                        dead_q <= 1'b0;
                        state_q <= ST_FETCH;
                    end
                end
                ST_FETCH:
                begin
                    // All units of the block are read back to back
                    if (memAck)
                    begin
                        if (wordIdx_q == 5'((zCnt_q << 2) - 4'h1))
                        begin
                            unitIdx_q <= 4'h0;
                            state_q <= ST_SCAN;
                        end
                        else
                        begin
                            wordIdx_q <= wordIdx_q + 5'h01;
                        end
                    end
                end
                ST_SCAN:
                begin
                    // Find the final descriptor, immediates span two units
                    if (unitIdx_q >= zCnt_q)
                    begin
                        dead_q <= 1'b1;
                        state_q <= ST_DEAD;
                    end
                    else if (unitW0[CMD_MSB:CMD_LSB] == CMD_LAST)
                    begin
                        lastUnit_q <= unitIdx_q;
                        tagOut_q <= firstTag;
                        state_q <= ST_CHECK;
                    end
                    else if (unitW0[KEY_MSB:KEY_LSB] == KEY_IMMEDIATE)
                    begin
                        unitIdx_q <= unitIdx_q + 4'h2;
                    end
                    else
                    begin
                        unitIdx_q <= unitIdx_q + 4'h1;
                    end
                end
                ST_CHECK:
                begin
                    // Requests skip the check; responses must still be live
                    if (!respCfg_q || sendOk)
                    begin
                        state_q <= ST_LOAD;
                    end
                    else
                    begin
                        evt_q <= EVT_TIMEOUT;
                        state_q <= lastW0[STATUS_WR_BIT] ? ST_WRBACK : ST_NEXT;
                    end
                end
                ST_LOAD:
                begin
                    // Verdict already taken, no second look here
                    if (pktReady)
                        state_q <= ST_WAITACK;
                end
                ST_WAITACK:
                begin
                    if (ackValid && ackRetry)
                    begin
                        // Retries of responses are checked again
                        state_q <= respCfg_q ? ST_CHECK : ST_LOAD;
                    end
                    else if (ackValid)
                    begin
                        evt_q <= ackCode;
                        if (!respCfg_q)
                            tagOut_q <= busCycleTimer;
                        state_q <= lastW0[STATUS_WR_BIT] ? ST_WRBACK : ST_NEXT;
                    end
                end
                ST_WRBACK:
                begin
                    if (memAck)
                        state_q <= ST_NEXT;
                end
                ST_NEXT:
                begin
                    // Follow the final descriptor's branch
                    if (lastBr[3:0] == Z_END)
                    begin
                        brAddr_q <= lastAddr + 32'(WORD_BRANCH * 4);
                        state_q <= ST_ENDWAIT;
                    end
                    else
                    begin
                        blkAddr_q <= {lastBr[31:4], 4'h0};
                        zCnt_q <= lastBr[3:0];
                        wordIdx_q <= 5'h00;
                        state_q <= ST_FETCH;
                    end
                end
                ST_ENDWAIT:
                begin
                    // Parked at the end until software appends
                    if (!runCfg_q)
                        state_q <= ST_IDLE;
                    else if (wakePulse)
                        state_q <= ST_RDBR;
                end
                ST_RDBR:
                begin
                    // Reread the end branch word; still zero means park again
                    if (memAck)
                    begin
                        if (memRdata[3:0] == Z_END)
                        begin
                            state_q <= ST_ENDWAIT;
                        end
                        else
                        begin
                            blkAddr_q <= {memRdata[31:4], 4'h0};
                            zCnt_q <= memRdata[3:0];
                            wordIdx_q <= 5'h00;
                            state_q <= ST_FETCH;
                        end
                    end
                end
                ST_DEAD:
                begin
                    // Only stopping the context leaves this state
                    if (!runCfg_q)
                        state_q <= ST_IDLE;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_zero_stops: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_q == ST_NEXT && lastBr[3:0] == Z_END) |=> state_q == ST_ENDWAIT)
        else $error("zero block count did not stop");
    a_fetch_length: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_q == ST_SCAN && $past(state_q) == ST_FETCH) |->
        $past(wordIdx_q) == 5'((zCnt_q << 2) - 4'h1))
        else $error("fetched word count wrong");
    a_late_reject: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_q == ST_CHECK && respCfg_q && secDiff[2]) |=> state_q != ST_LOAD)
        else $error("late response was loaded");
    a_far_send: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_q == ST_CHECK && respCfg_q && !secDiff[2] && secDiff[1:0] != 2'b00) |=> state_q == ST_LOAD)
        else $error("future response not sent");
    a_same_second: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_q == ST_CHECK && respCfg_q && secDiff == 3'b000) |=>
        (state_q == ST_LOAD) == ($past(firstTag[12:0]) >= $past(busCycleTimer[12:0])))
        else $error("cycle compare wrong");
    a_timeout_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_q == ST_CHECK && respCfg_q && !sendOk) |=> evt_q == EVT_TIMEOUT)
        else $error("timeout code not recorded");
    a_wb_word: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (memReq && memWe) |-> memWdata[15:0] == tagOut_q && memWdata[20:16] == evt_q &&
        memWdata[31] == runCfg_q && memAddr == blkAddr_q + {24'h0, lastUnit_q, 4'hc})
        else $error("write-back word wrong");
    a_req_tag: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_q == ST_WAITACK && ackValid && !ackRetry && !respCfg_q) |=>
        tagOut_q == $past(busCycleTimer))
        else $error("request tag not sampled at ack");
    a_wb_gated: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_q == ST_WAITACK && ackValid && !ackRetry) |=>
        (state_q == ST_WRBACK) == $past(lastW0[STATUS_WR_BIT]))
        else $error("write-back not gated by status bit");
    a_no_recheck: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state_q == ST_LOAD |=> state_q == ST_LOAD || state_q == ST_WAITACK)
        else $error("loading packet was rechecked");
endmodule

// *** test/atde_mem_model.sv ***
// Purpose: Host memory model holding descriptor programs
// Assumes: All descriptor words sit below byte 0x100
// Notes:   Ack latency comes from the bench, 0 is prompt
`timescale 1ns/1ps
module atde_mem_model
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Memory port
    input wire logic memReq,
    input wire logic memWe,
    input wire logic [31:0] memAddr,
    input wire logic [31:0] memWdata,
    output logic memAck,
    output logic [31:0] memRdata
);
    logic [31:0] mem [0:63]; // Word storage
    logic [31:0] rdQ; // Last word read
    logic [31:0] wrAddr; // Last write address
    logic [31:0] wrData; // Last write word
    int lat; // Idle cycles before ack
    int waitCnt;
    int rdCount;
    int wrCount;
    ////////////////////////////////////////////////////////////////
    // Answer each request once, after lat idle cycles
    // Plain always: the bench preloads words into mem directly
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            memAck <= 1'b0;
            waitCnt <= 0;
            rdCount <= 0;
            wrCount <= 0;
        end
        else if (memReq && !memAck && waitCnt < lat)
            waitCnt <= waitCnt + 1;
        else
        begin
            memAck <= memReq && !memAck;
            waitCnt <= 0;
            // Tag and status land as one word
            if (memReq && !memAck && memWe)
            begin
                mem[memAddr[7:2]] <= memWdata;
                wrAddr <= memAddr;
                wrData <= memWdata;
                wrCount <= wrCount + 1;
            end
            else if (memReq && !memAck)
            begin
                rdQ <= mem[memAddr[7:2]];
                rdCount <= rdCount + 1;
            end
        end
    end
    // Stale data inverted so it never passes for valid
    assign memRdata = memAck ? rdQ : ~rdQ;
endmodule

// *** test/atde_top_test.sv ***
// Purpose: Self-checking bench for descriptor fetch and expiry
// Assumes: Memory model answers every request
// Notes:   Expiry cases run in the response context
`timescale 1ns/1ps
module atde_top_test import atde_pkg::*;;
    logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, memAddr, memWdata, memRdata, rd, wD;
    logic memReq, memWe, memAck, pktValid, pktReady, ackValid, ackRetry;
    logic [15:0] busCycleTimer;
    logic [4:0] ackCode;
    int n_fail = 0;
    int cmp_count = 0;
    int nRd, nWr;
    assign nRd = atde_mem_model_inst.rdCount;
    assign nWr = atde_mem_model_inst.wrCount;
    assign wD = atde_mem_model_inst.wrData;
    atde_top #(.MAX_UNITS(8)) atde_top_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
        .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata), .busCycleTimer(busCycleTimer),
        .pktValid(pktValid), .pktReady(pktReady), .ackValid(ackValid), .ackRetry(ackRetry),
        .ackCode(ackCode));
    atde_mem_model atde_mem_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .memReq(memReq),
        .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata));
    ////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // One APB transfer, request held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Link acknowledge pulse
    task automatic ack(input logic rty, input logic [4:0] code);
        @(posedge clk_sys);
        ackValid <= 1'b1;
        ackRetry <= rty;
        ackCode <= code;
        @(posedge clk_sys);
        ackValid <= 1'b0;
    endtask
    // Wait for the packet offer and accept it
    task automatic take();
        for (int i = 0; i < 200 && pktValid !== 1'b1; i++) @(posedge clk_sys);
        check({31'h0, pktValid}, 32'h1);
        pktReady <= 1'b1;
        @(posedge clk_sys);
        pktReady <= 1'b0;
    endtask
    task automatic waitWr(input int n);
        for (int i = 0; i < 200 && nWr == n; i++) @(posedge clk_sys);
        check(nWr, n + 1);
    endtask
    // Two-unit block: one immediate final descriptor at word index b
    task automatic block(input int b, input logic s, input logic [15:0] tag, input logic [31:0] br);
        for (int i = 0; i < 8; i++) atde_mem_model_inst.mem[b + i] = 32'h0;
        atde_mem_model_inst.mem[b] = {CMD_LAST, s, KEY_IMMEDIATE, 24'h0};
        atde_mem_model_inst.mem[b + WORD_BRANCH] = br;
        atde_mem_model_inst.mem[b + WORD_STATUS] = {16'h0, tag};
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_regs();
        apb(0, REG_CMDPTR, 0);
        check(rd, CMDPTR_RESET);
        apb(0, 8'h0c, 0);
        check({31'h0, err}, 32'h1);
        // Zero count must not start any fetch
        apb(1, REG_CMDPTR, 32'h40);
        apb(1, REG_CTRL, 32'h1);
        repeat (20) @(posedge clk_sys);
        check(nRd, 0);
        // Block with no final descriptor must park the engine as dead
        for (int i = 0; i < 8; i++) atde_mem_model_inst.mem[i] = 32'h0;
        apb(1, REG_CMDPTR, 32'h2);
        repeat (60) @(posedge clk_sys);
        apb(0, REG_STATUS, 0);
        check({31'h0, rd[CCW_DEAD_BIT]}, 32'h1);
        apb(1, REG_CTRL, 0);
        $display("t_regs done");
    endtask
    // Request packet, then append and wake
    task automatic t_req();
        int w0;
        w0 = nWr;
        block(16, 1, 16'h0, 32'h0);
        apb(1, REG_CMDPTR, 32'h42);
        apb(1, REG_CTRL, 32'h1);
        take();
        busCycleTimer <= 16'ha123;
        ack(0, 5'h11);
        busCycleTimer <= 16'h0456;
        waitWr(w0);
        check(nRd, 16);
        check(atde_mem_model_inst.wrAddr, 32'h4c);
        check({16'h0, wD[15:0]}, 32'ha123);
        check({27'h0, wD[20:16]}, 32'h11);
        apb(0, REG_STATUS, 0);
        check({28'h0, rd[19:16]}, 32'h8);
        block(32, 0, 16'h0, 32'h0);
        atde_mem_model_inst.mem[18] = 32'h82;
        apb(1, REG_CTRL, 32'h5);
        take();
        // Request retry reloads without a new check
        ack(1, 5'h11);
        take();
        ack(0, 5'h11);
        repeat (10) @(posedge clk_sys);
        check(nWr, w0 + 1);
        check(nRd, 25);
        apb(1, REG_CTRL, 0);
        $display("t_req done");
    endtask
    // One response expiry case, optional retry after the timer moves on
    task automatic exp1(input logic [15:0] tag, input logic [15:0] tm, input logic go, input logic rty);
        int w0;
        logic sent;
        w0 = nWr;
        sent = 1'b0;
        block(48, 1, tag, 32'h0);
        busCycleTimer <= tm;
        apb(1, REG_CMDPTR, 32'hc2);
        apb(1, REG_CTRL, 32'h3);
        for (int i = 0; i < 100 && !sent && nWr == w0; i++)
        begin
            @(posedge clk_sys);
            sent = (pktValid === 1'b1);
        end
        check({31'h0, sent}, {31'h0, go});
        if (sent)
        begin
            take();
            busCycleTimer <= tm + 16'h1;
            ack(rty, 5'h11);
        end
        waitWr(w0);
        check({27'h0, wD[20:16]}, (go && !rty) ? 32'h11 : {27'h0, EVT_TIMEOUT});
        apb(1, REG_CTRL, 0);
    endtask
    task automatic t_exp();
        logic [15:0] tg [7] = '{16'h8000, 16'h6000, 16'h0fa0, 16'h0fa0, 16'h0fa0, 16'h0000, 16'h0000};
        logic [15:0] tm [7] = '{16'h0000, 16'h0000, 16'h0f9e, 16'h0fa0, 16'h0fa1, 16'h1f3f, 16'h2000};
        logic [6:0] go = 7'b0001110;
        for (int k = 0; k < 7; k++) exp1(tg[k], tm[k], go[k], 1'b0);
        exp1(16'h0fa0, 16'h0fa0, 1'b1, 1'b1);
        $display("t_exp done");
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Main sequence: slow memory first, prompt for expiry cases
    initial
    begin
        {sys_rst, psel, penable, pwrite, pktReady, ackValid, ackRetry} = 7'h40;
        {paddr, pwdata, busCycleTimer, ackCode} = '0;
        atde_mem_model_inst.lat = 2;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_regs();
        t_req();
        atde_mem_model_inst.lat = 0;
        t_exp();
        test_done();
    end
    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        test_done();
    end
endmodule
